// ---- hdl/dmaar_regs.vh ----
// register offsets, field positions, reset values and constants for the dma address block
`ifndef DMAAR_REGS_VH
`define DMAAR_REGS_VH
`define DMAAR_AW 32
`define DMAAR_DW 16
`define DMAAR_OFF_AOUT_HI 32'h0b00002e
`define DMAAR_OFF_IR_BASE_LO 32'h0b000030
`define DMAAR_OFF_IR_BASE_HI 32'h0b000032
`define DMAAR_OFF_IR_NEXT_LO 32'h0b000034
`define DMAAR_OFF_IR_NEXT_HI 32'h0b000036
`define DMAAR_OFF_CTRL 32'h0b000040
`define DMAAR_OFF_MASK 32'h0b000046
`define DMAAR_OFF_STAT 32'h0b000042
`define DMAAR_LO_RESET 16'hf800
`define DMAAR_HI_RESET 16'h01ff
`define DMAAR_HI_MASK 16'h01ff
`define DMAAR_ORIGIN_MASK 32'hfffffc00
`define DMAAR_BUF_BYTES 32'h00000800
`define DMAAR_STEP 32'h00000002
`define DMAAR_MSK_AIN 3
`define DMAAR_MSK_AOUT 2
`define DMAAR_MSK_IR 0
`define DMAAR_MSK_WMASK 4'hd
`define DMAAR_CH_NONE 2'h0
`define DMAAR_CH_AIN 2'h1
`define DMAAR_CH_AOUT 2'h2
`define DMAAR_CH_IR 2'h3
`endif

// ---- hdl/dmaar_arbiter.v ----
// fixed-priority request arbiter for the three dma channels
`include "dmaar_regs.vh"
module dmaar_arbiter (
	input wire ain_req_in,
	input wire aout_req_in,
	input wire ir_req_in,
	output reg [1:0] pick_out
);
	always @* begin
		if (ain_req_in) begin
			pick_out = `DMAAR_CH_AIN;
		end else if (aout_req_in) begin
			pick_out = `DMAAR_CH_AOUT;
		end else if (ir_req_in) begin
			pick_out = `DMAAR_CH_IR;
		end else begin
			pick_out = `DMAAR_CH_NONE;
		end
	end
endmodule

// ---- hdl/dmaar_skid.v ----
// two-entry valid/ready buffer for issued transfer addresses
module dmaar_skid (
	input wire clk_in,
	input wire rstn_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [33:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [33:0] out_data_out
);
	reg [33:0] mem [0:1];
	reg rd_ptr;
	reg wr_ptr;
	reg [1:0] count;
	wire push;
	wire pop;
	assign in_ready_out = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	// storage carries no reset; only the occupancy count defines validity
	always @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	// pointer and occupancy update
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push & ~pop) begin
				count <= count + 2'h1;
			end else if (pop & ~push) begin
				count <= count - 2'h1;
			end
		end
	end
endmodule

// ---- hdl/dmaar_top.v ----
// dma channel address registers, arbitration and address issue
`include "dmaar_regs.vh"
module dmaar_top (
	input wire CLK_SYS_IN,
	input wire RSTN_IN,
	input wire [31:0] ADDR_IN,
	input wire [15:0] WDATA_IN,
	input wire WR_IN,
	input wire RD_IN,
	output reg [15:0] RDATA_OUT,
	input wire AIN_REQ_IN,
	input wire AOUT_REQ_IN,
	input wire IR_REQ_IN,
	input wire [31:0] AIN_ADDR_IN,
	input wire [31:0] AOUT_ADDR_IN,
	output wire AIN_ACK_OUT,
	output wire AOUT_ACK_OUT,
	output wire IR_ACK_OUT,
	output wire XFER_VALID_OUT,
	input wire XFER_READY_IN,
	output wire [31:0] XFER_ADDR_OUT,
	output wire [1:0] XFER_CH_OUT,
	input wire BUS_GRANT_IN,
	output wire AOUT_DONE_OUT
);
	reg [15:0] ir_base_lo;
	reg [15:0] ir_base_hi;
	reg [15:0] ir_next_lo;
	reg [15:0] ir_next_hi;
	reg [15:0] aout_next_hi;
	reg ctrl_enable;
	reg [3:0] mask;
	reg ir_started;
	reg ir_reload;
	wire [1:0] pick;
	wire [1:0] gated_pick;
	wire buf_ready;
	wire push;
	wire [31:0] ir_next;
	wire [31:0] ir_base;
	wire [31:0] ir_advanced;
	wire [31:0] issue_addr;
	wire buf_valid;
	wire [33:0] buf_data;
	wire ain_ok;
	wire aout_ok;
	wire ir_ok;
	wire wr_ir_base;

	// address wrap inside the channel buffer
	function [31:0] dmaar_wrap;
		input [31:0] cur;
		input [31:0] start;
		reg [31:0] origin;
		reg [31:0] nxt;
		begin
			origin = start & `DMAAR_ORIGIN_MASK;
			nxt = cur + `DMAAR_STEP;
			if (nxt >= origin + `DMAAR_BUF_BYTES) begin
				dmaar_wrap = origin;
			end else begin
				dmaar_wrap = nxt;
			end
		end
	endfunction

	assign ir_base = {ir_base_hi, ir_base_lo};
	assign ir_next = {ir_next_hi, ir_next_lo};
	assign ir_advanced = dmaar_wrap(ir_next, ir_base);

	assign ain_ok = ctrl_enable & mask[`DMAAR_MSK_AIN] & AIN_REQ_IN;
	assign aout_ok = ctrl_enable & mask[`DMAAR_MSK_AOUT] & AOUT_REQ_IN;
	assign ir_ok = ctrl_enable & mask[`DMAAR_MSK_IR] & IR_REQ_IN;

	dmaar_arbiter u_arb (
		.ain_req_in(ain_ok),
		.aout_req_in(aout_ok),
		.ir_req_in(ir_ok),
		.pick_out(pick)
	);

	// grant from the bus unit lets a transfer out; buffer full stalls
	assign gated_pick = (BUS_GRANT_IN & buf_ready) ? pick : `DMAAR_CH_NONE;
	assign push = (gated_pick != `DMAAR_CH_NONE);
	assign AIN_ACK_OUT = (gated_pick == `DMAAR_CH_AIN);
	assign AOUT_ACK_OUT = (gated_pick == `DMAAR_CH_AOUT);
	assign IR_ACK_OUT = (gated_pick == `DMAAR_CH_IR);
	assign AOUT_DONE_OUT = AOUT_ACK_OUT;

	// first ir transfer uses the base
	assign issue_addr = (gated_pick == `DMAAR_CH_AIN) ? AIN_ADDR_IN :
		(gated_pick == `DMAAR_CH_AOUT) ? AOUT_ADDR_IN :
		(ir_started & ~ir_reload) ? ir_next : ir_base;

	dmaar_skid u_buf (
		.clk_in(CLK_SYS_IN),
		.rstn_in(RSTN_IN),
		.in_valid_in(push),
		.in_ready_out(buf_ready),
		.in_data_in({gated_pick, issue_addr}),
		.out_valid_out(buf_valid),
		.out_ready_in(XFER_READY_IN),
		.out_data_out(buf_data)
	);
	assign XFER_VALID_OUT = buf_valid;
	assign XFER_ADDR_OUT = buf_data[31:0];
	assign XFER_CH_OUT = buf_data[33:32];

	assign wr_ir_base = WR_IN & ((ADDR_IN == `DMAAR_OFF_IR_BASE_LO) | (ADDR_IN == `DMAAR_OFF_IR_BASE_HI));

	// register writes and channel address update
	always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ir_base_lo <= `DMAAR_LO_RESET;
			ir_base_hi <= `DMAAR_HI_RESET;
			ir_next_lo <= `DMAAR_LO_RESET;
			ir_next_hi <= `DMAAR_HI_RESET;
			aout_next_hi <= `DMAAR_HI_RESET;
			ctrl_enable <= 1'b0;
			mask <= 4'h0;
			ir_started <= 1'b0;
			ir_reload <= 1'b0;
		end else begin
			if (IR_ACK_OUT) begin
				ir_started <= 1'b1;
				ir_reload <= 1'b0;
				if (ir_started & ~ir_reload) begin
					{ir_next_hi, ir_next_lo} <= ir_advanced;
				end else begin
					{ir_next_hi, ir_next_lo} <= dmaar_wrap(ir_base, ir_base);
				end
			end
			// audio out high half tracks its channel
			if (AOUT_ACK_OUT) begin
				aout_next_hi <= AOUT_ADDR_IN[31:16] & `DMAAR_HI_MASK;
			end
			// a new base restarts the ir channel from it
			if (wr_ir_base) begin
				ir_reload <= 1'b1;
			end
			if (WR_IN) begin
				case (ADDR_IN)
					`DMAAR_OFF_IR_BASE_LO: ir_base_lo <= WDATA_IN;
					`DMAAR_OFF_IR_BASE_HI: ir_base_hi <= WDATA_IN & `DMAAR_HI_MASK;
					`DMAAR_OFF_IR_NEXT_LO: ir_next_lo <= WDATA_IN;
					`DMAAR_OFF_IR_NEXT_HI: ir_next_hi <= WDATA_IN & `DMAAR_HI_MASK;
					`DMAAR_OFF_AOUT_HI: aout_next_hi <= WDATA_IN & `DMAAR_HI_MASK;
					`DMAAR_OFF_CTRL: ctrl_enable <= WDATA_IN[0];
					`DMAAR_OFF_MASK: mask <= WDATA_IN[3:0] & `DMAAR_MSK_WMASK;
					default: ctrl_enable <= ctrl_enable;
				endcase
			end
		end
	end

	// readback one cycle after the strobe
	always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			RDATA_OUT <= 16'h0000;
		end else if (RD_IN) begin
			case (ADDR_IN)
				`DMAAR_OFF_AOUT_HI: RDATA_OUT <= aout_next_hi;
				`DMAAR_OFF_IR_BASE_LO: RDATA_OUT <= ir_base_lo;
				`DMAAR_OFF_IR_BASE_HI: RDATA_OUT <= ir_base_hi;
				`DMAAR_OFF_IR_NEXT_LO: RDATA_OUT <= ir_next_lo;
				`DMAAR_OFF_IR_NEXT_HI: RDATA_OUT <= ir_next_hi;
				`DMAAR_OFF_CTRL: RDATA_OUT <= {15'h0000, ctrl_enable};
				`DMAAR_OFF_MASK: RDATA_OUT <= {12'h000, mask};
				`DMAAR_OFF_STAT: RDATA_OUT <= {15'h0000, ~buf_valid};
				default: RDATA_OUT <= 16'h0000;
			endcase
		end else begin
			RDATA_OUT <= 16'h0000;
		end
	end
endmodule

// ---- testbench/dmaar_properties.sv ----
// port checks for the dma address block
module dmaar_props (
	input logic CLK_SYS_IN,
	input logic RSTN_IN,
	input logic [31:0] ADDR_IN,
	input logic RD_IN,
	input logic [15:0] RDATA_OUT,
	input logic IR_REQ_IN,
	input logic BUS_GRANT_IN,
	input logic XFER_READY_IN,
	input logic AIN_ACK_OUT,
	input logic AOUT_ACK_OUT,
	input logic IR_ACK_OUT,
	input logic AOUT_DONE_OUT,
	input logic XFER_VALID_OUT,
	input logic [31:0] XFER_ADDR_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);
	// any accepted request this cycle
	wire any_ack = AIN_ACK_OUT | AOUT_ACK_OUT | IR_ACK_OUT;
	// read of one of the three upper halves
	sequence hi_rd;
		RD_IN && (ADDR_IN == 32'h0b00002e || ADDR_IN == 32'h0b000032 || ADDR_IN == 32'h0b000036);
	endsequence
	one_ack_a: assert property ($onehot0({AIN_ACK_OUT, AOUT_ACK_OUT, IR_ACK_OUT}))
		else $error("two acks at once");
	grant_need_a: assert property (any_ack |-> BUS_GRANT_IN)
		else $error("ack without grant");
	ir_cause_a: assert property (IR_ACK_OUT |-> IR_REQ_IN)
		else $error("ack without request");
	ack_issue_a: assert property (any_ack |=> XFER_VALID_OUT)
		else $error("accepted transfer not issued");
	done_ack_a: assert property (AOUT_DONE_OUT == AOUT_ACK_OUT)
		else $error("done differs from ack");
	rd_idle_a: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
		else $error("read data without read");
	hi_zero_a: assert property (hi_rd |=> RDATA_OUT[15:9] == 7'h00)
		else $error("upper bits not zero");
	stall_hold_a: assert property (XFER_VALID_OUT && !XFER_READY_IN |=> XFER_VALID_OUT && $stable(XFER_ADDR_OUT))
		else $error("stalled word lost");
endmodule
bind dmaar_top dmaar_props i_chk (.*);

// ---- testbench/dmaar_partner.sv ----
// bus control stand-in: grants slots and takes issued transfers
module dmaar_partner (
	input logic clk_in,
	input logic rstn_in,
	input logic slow_in,
	output logic grant_out,
	output logic ready_out
);
	// grants bus slots
	// slow mode grants every other cycle and stalls the receiver
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grant_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			grant_out <= slow_in ? ~grant_out : 1'b1;
			ready_out <= !slow_in;
		end
	end
endmodule

// ---- testbench/dmaar_tb_top.sv ----
// self-checking bench for the dma address block
module dmaar_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_SYS_IN = 0, RSTN_IN = 0, WR_IN = 0, RD_IN = 0, slow = 0;
	logic AIN_REQ_IN = 0, AOUT_REQ_IN = 0, IR_REQ_IN = 0;
	logic [31:0] ADDR_IN = 0, AIN_ADDR_IN = 32'h00340000, AOUT_ADDR_IN = 32'hffa50000, e;
	logic [15:0] WDATA_IN = 0, RDATA_OUT;
	logic AIN_ACK_OUT, AOUT_ACK_OUT, IR_ACK_OUT, XFER_VALID_OUT, XFER_READY_IN, BUS_GRANT_IN, AOUT_DONE_OUT;
	logic [31:0] XFER_ADDR_OUT;
	logic [1:0] XFER_CH_OUT;
	int error_cnt = 0, checks_done = 0, i;
	// 8 ns clock
	always #4 CLK_SYS_IN = ~CLK_SYS_IN;
	dmaar_top i_dut (.*);
	dmaar_partner i_bus (.clk_in(CLK_SYS_IN), .rstn_in(RSTN_IN), .slow_in(slow), .grant_out(BUS_GRANT_IN),
		.ready_out(XFER_READY_IN));
	task chk(input string n, input logic [31:0] x, input logic [31:0] y);
		checks_done++;
		if (x !== y) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, x, y);
		end
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge CLK_SYS_IN);
		ADDR_IN <= a;
		WDATA_IN <= d;
		WR_IN <= 1'b1;
		@(posedge CLK_SYS_IN);
		WR_IN <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input logic [31:0] a, input logic [15:0] x);
		@(posedge CLK_SYS_IN);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		@(posedge CLK_SYS_IN);
		RD_IN <= 1'b0;
		#1 chk("rdata", x, RDATA_OUT);
	endtask
	task req(input logic v);
		@(posedge CLK_SYS_IN);
		IR_REQ_IN <= v;
	endtask
	task quiet;
		repeat (4) begin
			@(negedge CLK_SYS_IN);
			chk("ir ack", 0, IR_ACK_OUT);
		end
	endtask
	// bounded wait for a handshake, then compare the issued address
	task xf(input logic [31:0] x);
		for (i = 0; i < 50; i++) begin
			@(negedge CLK_SYS_IN);
			if (XFER_VALID_OUT === 1'b1 && XFER_READY_IN === 1'b1)
				break;
		end
		chk("xfer addr", x, XFER_ADDR_OUT);
		chk("xfer ch", 32'h3, {30'h0, XFER_CH_OUT});
		if (i == 50) begin
			error_cnt++;
			test_done();
		end
		@(posedge CLK_SYS_IN);
	endtask
	task t_regs;
		rd(32'h0b00002e, 16'h01ff);
		rd(32'h0b000030, 16'hf800);
		rd(32'h0b000032, 16'h01ff);
		rd(32'h0b000034, 16'hf800);
		rd(32'h0b000036, 16'h01ff);
		rd(32'h0b000038, 16'h0000);
		wr(32'h0b000032, 16'hffff);
		rd(32'h0b000032, 16'h01ff);
		wr(32'h0b000046, 16'hffff);
		rd(32'h0b000046, 16'h000d);
	endtask
	// disabled controller and cleared mask both refuse
	task t_off;
		req(1);
		quiet();
		req(0);
		wr(32'h0b000040, 16'h0001);
		wr(32'h0b000046, 16'h0000);
		req(1);
		quiet();
		req(0);
	endtask
	task t_pri;
		wr(32'h0b000046, 16'h000d);
		@(posedge CLK_SYS_IN);
		AIN_REQ_IN <= 1;
		AOUT_REQ_IN <= 1;
		IR_REQ_IN <= 1;
		@(negedge CLK_SYS_IN);
		chk("acks", 3'b100, {AIN_ACK_OUT, AOUT_ACK_OUT, IR_ACK_OUT});
		@(posedge CLK_SYS_IN);
		AIN_REQ_IN <= 0;
		@(negedge CLK_SYS_IN);
		chk("acks", 3'b010, {AIN_ACK_OUT, AOUT_ACK_OUT, IR_ACK_OUT});
		@(posedge CLK_SYS_IN);
		AOUT_REQ_IN <= 0;
		@(negedge CLK_SYS_IN);
		chk("acks", 3'b001, {AIN_ACK_OUT, AOUT_ACK_OUT, IR_ACK_OUT});
		req(0);
		rd(32'h0b00002e, 16'h01a5);
	endtask
	// stream past the buffer end to see the wrap to its origin
	task t_ir;
		wr(32'h0b000030, 16'h03fe);
		wr(32'h0b000032, 16'h0012);
		req(1);
		e = 32'h001203fe;
		repeat (520) begin
			xf(e);
			e = (e + 2 >= 32'h00120800) ? 32'h00120000 : e + 2;
		end
		req(0);
		rd(32'h0b000036, 16'h0012);
	endtask
	task t_buf;
		@(posedge CLK_SYS_IN);
		slow <= 1;
		req(1);
		repeat (12) @(posedge CLK_SYS_IN);
		quiet();
		rd(32'h0b000042, 16'h0000);
		req(0);
		slow <= 0;
		repeat (6) @(posedge CLK_SYS_IN);
		rd(32'h0b000042, 16'h0001);
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge CLK_SYS_IN);
		RSTN_IN <= 1'b1;
		t_regs();
		t_off();
		t_pri();
		t_ir();
		t_buf();
		test_done();
	end
endmodule
